// ### bdc_pkg.sv
package bdc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam int AW = 12;
  localparam logic [11:0] OFF_PCI_ADDR = 12'h404;
  localparam logic [11:0] OFF_CNT = 12'h408;
  localparam logic [11:0] OFF_LOCAL = 12'h40C;
  localparam logic [11:0] OFF_CTRL = 12'h410;
  localparam logic [11:0] OFF_PTR = 12'h414;

  // ---------------------------------------------------------------
  // field masks and values
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] CNT_MASK = 32'h00FF_FFFC;
  localparam logic [31:0] PKT_CNT_MASK = 32'h000F_FFFC;
  localparam logic [31:0] PTR_MASK = 32'hFFFF_FFF0;
  localparam logic [31:0] CS_WMASK = 32'hF7F7_C380;
  localparam logic [31:0] CS_PKT_MASK = 32'hF7F0_0000;
  localparam logic [31:0] WRAP_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] MIN_BYTES = 32'h0000_0010;
  localparam logic [31:0] BND_WIDE = 32'h0000_00FF;
  localparam logic [31:0] BND_NARROW = 32'h0000_003F;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] WM_CL = 4'h0;
  localparam logic [3:0] WM_MAX = 4'h8;
  localparam logic [10:0] OFF_0 = 11'h000;
  localparam logic [10:0] OFF_64 = 11'h040;
  localparam logic [10:0] OFF_128 = 11'h080;
  localparam logic [10:0] OFF_256 = 11'h100;
  localparam logic [10:0] OFF_512 = 11'h200;
  localparam logic [10:0] OFF_1024 = 11'h400;

  // ---------------------------------------------------------------
  // control word bit positions
  // ---------------------------------------------------------------
  localparam int TC_LSB = 28;
  localparam int DIR_BIT = 27;
  localparam int DEST_PORT_WIDTH_LSB = 25;
  localparam int ENDIAN_INVERT_BIT = 24;
  localparam int WM_LSB = 20;
  localparam int QOFF_LSB = 16;
  localparam int B4_BIT = 15;
  localparam int BEN_BIT = 14;
  localparam int MAX_BURST_SIZE_BIT = 9;
  localparam int LOC_BIT = 8;
  localparam int STOP_BIT = 7;
  localparam int SSTAT_BIT = 6;
  localparam int LAST_BIT = 0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN = 2'b10,
    ST_DRAIN = 2'b11
  } bdc_state_e;

  typedef enum logic [1:0] {
    SZ_32 = 2'b00,
    SZ_8 = 2'b01,
    SZ_16 = 2'b10,
    SZ_RSVD = 2'b11
  } bdc_size_e;

  typedef struct packed {
    logic [31:0] pci_addr;
    logic [31:0] local_addr;
    logic [31:0] cnt_ctrl;
    logic [31:0] next_ptr;
  } bdc_pkt_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] tc;
    bdc_size_e size;
    logic burst;
    logic swap;
  } bdc_lb_s;

endpackage : bdc_pkg

// ### bdc_dma_channel.sv
`timescale 1ns/1ns

module bdc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [LW-1:0] cnt_reg;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  assign in_ready = cnt_reg != LW'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign level = cnt_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      cnt_reg <= cnt_reg + LW'(push) - LW'(pop);
    end
  end
endmodule : bdc_fifo

// How it works
// RL1 - PCI address is word aligned and advances with every PCI-side word.
// RL2 - Address increments wrap inside the current 24-bit window.
// RL3 - Byte count in bits 23:2 drops by four per PCI-side word.
// RL4 - One transaction may move up to sixteen megabytes.
// RL5 - Start is ignored outside chain mode while the byte count is below sixteen.
// RL6 - Software keeps the byte count at or above the watermark.
// RL7 - Packet loads take only count bits 19:2, one megabyte at most.
// RL8 - Address and count registers load from software or command packets.
// RL9 - Local address is word aligned, wraps at 24 bits, never advances.
// RL10 - Control direction bit is a read-only mirror of the shared bit.
// RL11 - Port width field: 00 wide, 01 byte, 10 half, 11 reserved.
// RL12 - Endian invert flips the global local-bus byte order.
// RL13 - Watermark: zero uses cache line, else 16x bytes, max 128.
// RL14 - Off counter holds local requests for 0 to 1024 clocks.
// RL15 - Off counter restarts at each 256 or 64 byte boundary.
// RL16 - Burst size bit picks the 256 or 64 byte boundary for the off counter; the burst flag ignores it.
// RL17 - Four-beat bit forbids partial bursts of two or three beats.
// RL18 - Bursts only when enabled and strapped into burst master mode.
// RL19 - Stop halts after the beat in flight; writing zero resumes.
// RL20 - Control bits 31:28 and 26:20 also load from each command packet.
// RL21 - Packet location bit picks PCI or local memory for fetches.
// RL22 - Programmed transaction code is driven on every local beat.
// RL23 - Packet pointer is 16-byte aligned and follows each packet.
// RL24 - Count expiry in direct mode or on the last packet sets done and returns the channel to idle.
// RL25 - Reserved bits read zero and ignore writes.
module bdc_dma_channel #(
  parameter int DEPTH = 4
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [bdc_pkg::AW-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_ACK,
  input wire logic START,
  input wire logic CHAIN_MODE,
  input wire logic SHARED_DIR,
  input wire logic GLOBAL_BYTE_ORDER,
  input wire logic BURST_MASTER_MODE,
  input wire logic [1:0] CACHE_LINE_SETTING,
  input wire logic IN_VALID,
  input wire logic [31:0] IN_DATA,
  output logic IN_READY,
  output logic PCI_REQ,
  output logic [31:0] PCI_ADDR,
  output logic LB_VALID,
  input wire logic LB_ACK,
  output bdc_pkg::bdc_lb_s LB_BEAT,
  output logic PKT_REQ,
  output logic [31:0] PKT_ADDR,
  output logic PKT_FROM_LOCAL,
  input wire logic PKT_VALID,
  input wire bdc_pkg::bdc_pkt_s PKT,
  output logic ACTIVE,
  output logic DONE,
  output logic STOPPED
);
  localparam int LW = $clog2(DEPTH+1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bdc_pkg::bdc_state_e state_reg;
  bdc_pkg::bdc_state_e state_next;
  bdc_pkg::bdc_lb_s lb_reg;
  logic [31:0] pci_reg;
  logic [31:0] cnt_reg;
  logic [31:0] local_reg;
  logic [31:0] cs_reg;
  logic [31:0] ptr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] ofs_reg;
  logic [31:0] pkt_addr_reg;
  logic [10:0] off_reg;
  logic ack_reg;
  logic chain_reg;
  logic last_reg;
  logic done_reg;
  logic active_reg;
  logic stopped_reg;
  logic in_rdy_reg;
  logic pci_req_reg;
  logic lb_valid_reg;
  logic pkt_req_reg;
  logic pkt_loc_reg;
  logic strap_reg;
  logic strap_done_reg;
  logic fifo_in_ready;
  logic fifo_ov;
  logic [31:0] fifo_od;
  logic [LW-1:0] lvl;
  logic [LW-1:0] lvl_next;
  logic [31:0] cnt_next;
  logic [5:0] thr;
  logic push;
  logic pop;
  logic lb_done;
  logic lb_valid_next;
  logic pkt_take;
  logic start_ok;
  logic drained;
  logic stop;
  logic stop_next;
  logic run_go;
  logic idle;
  logic burst_ok;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] wrap_add(input logic [31:0] a,
                                           input logic [31:0] s);
    return (a & ~bdc_pkg::WRAP_MASK) | ((a + s) & bdc_pkg::WRAP_MASK);
  endfunction : wrap_add

  function automatic logic [10:0] off_cycles(input logic [2:0] code);
    case (code)
      3'h1: return bdc_pkg::OFF_64;
      3'h2: return bdc_pkg::OFF_128;
      3'h3: return bdc_pkg::OFF_256;
      3'h4: return bdc_pkg::OFF_512;
      3'h5: return bdc_pkg::OFF_1024;
      default: return bdc_pkg::OFF_0;
    endcase
  endfunction : off_cycles

  function automatic logic [5:0] wm_words(input logic [3:0] wm,
                                          input logic [1:0] cl);
    logic [3:0] w;
    w = (wm > bdc_pkg::WM_MAX) ? bdc_pkg::WM_MAX : wm;
    if (wm == bdc_pkg::WM_CL) begin
      w = {2'b00, cl} + 4'h1;
    end
    return {w, 2'b00};
  endfunction : wm_words

  function automatic logic wr_hit(input logic [11:0] off);
    return REG_WR && (REG_ADDR == off);
  endfunction : wr_hit

  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  bdc_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_data(IN_DATA),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_ov),
    .out_data(fifo_od),
    .out_ready(pop),
    .level(lvl)
  );

  assign stop = cs_reg[bdc_pkg::STOP_BIT];
  // stop as it will stand after this edge, so ready drops with it
  assign stop_next = (!pkt_take && REG_WR && REG_ADDR == bdc_pkg::OFF_CTRL)
                     ? REG_WDATA[bdc_pkg::STOP_BIT] : stop; // RL19
  assign idle = state_reg == bdc_pkg::ST_IDLE;
  assign run_go = !stop && !idle && state_reg != bdc_pkg::ST_FETCH;
  assign push = IN_VALID && in_rdy_reg && fifo_in_ready;
  assign lb_done = lb_valid_reg && LB_ACK;
  assign pop = (!lb_valid_reg || LB_ACK) && fifo_ov && run_go
               && off_reg == bdc_pkg::OFF_0; // RL14 RL19
  assign lb_valid_next = pop || (lb_valid_reg && !LB_ACK);
  assign lvl_next = lvl + LW'(push) - LW'(pop);
  assign cnt_next = push ? cnt_reg - bdc_pkg::WORD_BYTES : cnt_reg; // RL3
  assign pkt_take = pkt_req_reg && PKT_VALID;
  assign start_ok = START && (CHAIN_MODE ||
                    cnt_reg >= bdc_pkg::MIN_BYTES); // RL5
  assign drained = lvl == '0 && !lb_valid_reg;
  assign thr = wm_words(cs_reg[bdc_pkg::WM_LSB +: 4],
                        CACHE_LINE_SETTING); // RL13
  assign burst_ok = cs_reg[bdc_pkg::BEN_BIT] && strap_reg && // RL18
                    (cs_reg[bdc_pkg::B4_BIT] ? lvl >= LW'(4)
                                             : lvl >= LW'(2)); // RL17

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bdc_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_next = CHAIN_MODE ? bdc_pkg::ST_FETCH : bdc_pkg::ST_RUN;
        end
      end
      bdc_pkg::ST_FETCH: begin
        if (pkt_take) begin
          state_next = ((PKT.cnt_ctrl & bdc_pkg::PKT_CNT_MASK)
                        >= bdc_pkg::MIN_BYTES) ? bdc_pkg::ST_RUN
                                               : bdc_pkg::ST_IDLE;
        end
      end
      bdc_pkg::ST_RUN: begin
        if (cnt_reg == bdc_pkg::ZERO_WORD) begin
          state_next = bdc_pkg::ST_DRAIN;
        end
      end
      default: begin
        if (drained) begin
          state_next = (chain_reg && !last_reg) ? bdc_pkg::ST_FETCH
                                                : bdc_pkg::ST_IDLE; // RL24
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= bdc_pkg::ST_IDLE;
      chain_reg <= 1'b0;
      last_reg <= 1'b0;
      done_reg <= 1'b0;
      active_reg <= 1'b0;
      stopped_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      active_reg <= state_next != bdc_pkg::ST_IDLE; // RL24
      if (idle && start_ok) begin
        chain_reg <= CHAIN_MODE;
        last_reg <= 1'b0;
        done_reg <= 1'b0;
      end else if (!idle && state_next == bdc_pkg::ST_IDLE) begin
        done_reg <= 1'b1; // RL24
      end
      if (pkt_take) begin
        last_reg <= PKT.next_ptr[bdc_pkg::LAST_BIT];
      end
      stopped_reg <= stop && state_next != bdc_pkg::ST_IDLE
                     && !lb_valid_next; // RL19
    end
  end

  // ---------------------------------------------------------------
  // channel registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pci_reg <= bdc_pkg::ZERO_WORD;
      cnt_reg <= bdc_pkg::ZERO_WORD;
      local_reg <= bdc_pkg::ZERO_WORD;
      ptr_reg <= bdc_pkg::ZERO_WORD;
    end else begin
      if (pkt_take) begin
        pci_reg <= PKT.pci_addr & bdc_pkg::ADDR_MASK; // RL8
        cnt_reg <= PKT.cnt_ctrl & bdc_pkg::PKT_CNT_MASK; // RL7
        local_reg <= PKT.local_addr & bdc_pkg::ADDR_MASK; // RL9
        ptr_reg <= PKT.next_ptr & bdc_pkg::PTR_MASK; // RL23
      end else if (idle) begin
        if (wr_hit(bdc_pkg::OFF_PCI_ADDR)) begin
          pci_reg <= REG_WDATA & bdc_pkg::ADDR_MASK; // RL1
        end
        if (wr_hit(bdc_pkg::OFF_CNT)) begin
          cnt_reg <= REG_WDATA & bdc_pkg::CNT_MASK; // RL4 RL25
        end
        if (wr_hit(bdc_pkg::OFF_LOCAL)) begin
          local_reg <= REG_WDATA & bdc_pkg::ADDR_MASK;
        end
        if (wr_hit(bdc_pkg::OFF_PTR)) begin
          ptr_reg <= REG_WDATA & bdc_pkg::PTR_MASK;
        end
      end else if (push) begin
        pci_reg <= wrap_add(pci_reg, bdc_pkg::WORD_BYTES); // RL1 RL2
        cnt_reg <= cnt_next;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_reg <= bdc_pkg::ZERO_WORD;
    end else if (pkt_take) begin
      cs_reg <= (cs_reg & ~bdc_pkg::CS_PKT_MASK)
                | (PKT.cnt_ctrl & bdc_pkg::CS_PKT_MASK); // RL20
    end else if (wr_hit(bdc_pkg::OFF_CTRL)) begin
      cs_reg <= REG_WDATA & bdc_pkg::CS_WMASK; // RL25 RL19
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= bdc_pkg::ZERO_WORD;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= REG_WR || REG_RD;
      if (!REG_RD) begin
        rdata_reg <= bdc_pkg::ZERO_WORD;
      end else if (REG_ADDR == bdc_pkg::OFF_PCI_ADDR) begin
        rdata_reg <= pci_reg;
      end else if (REG_ADDR == bdc_pkg::OFF_CNT) begin
        rdata_reg <= cnt_reg;
      end else if (REG_ADDR == bdc_pkg::OFF_LOCAL) begin
        rdata_reg <= local_reg;
      end else if (REG_ADDR == bdc_pkg::OFF_CTRL) begin
        rdata_reg <= cs_reg;
        rdata_reg[bdc_pkg::DIR_BIT] <= SHARED_DIR; // RL10
        rdata_reg[bdc_pkg::SSTAT_BIT] <= stopped_reg;
      end else if (REG_ADDR == bdc_pkg::OFF_PTR) begin
        rdata_reg <= ptr_reg;
      end else begin
        rdata_reg <= bdc_pkg::ZERO_WORD;
      end
    end
  end

  // ---------------------------------------------------------------
  // PCI side and packet fetch
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_rdy_reg <= 1'b0;
      pci_req_reg <= 1'b0;
      pkt_req_reg <= 1'b0;
      pkt_addr_reg <= bdc_pkg::ZERO_WORD;
      pkt_loc_reg <= 1'b0;
    end else begin
      in_rdy_reg <= state_next == bdc_pkg::ST_RUN && !stop_next
                    && cnt_next != bdc_pkg::ZERO_WORD
                    && lvl_next < LW'(DEPTH);
      pci_req_reg <= state_next == bdc_pkg::ST_RUN && !stop_next
                     && (6'(DEPTH) - 6'(lvl_next) >= thr
                         || lvl_next == '0); // RL13
      pkt_req_reg <= state_next == bdc_pkg::ST_FETCH;
      pkt_addr_reg <= ptr_reg; // RL23
      pkt_loc_reg <= cs_reg[bdc_pkg::LOC_BIT]; // RL21
    end
  end

  // ---------------------------------------------------------------
  // local bus side
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg <= BURST_MASTER_MODE; // RL18
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lb_reg <= '0;
      lb_valid_reg <= 1'b0;
      ofs_reg <= bdc_pkg::ZERO_WORD;
    end else begin
      lb_valid_reg <= lb_valid_next;
      if ((idle && start_ok) || pkt_take) begin
        ofs_reg <= bdc_pkg::ZERO_WORD;
      end else if (pop) begin
        ofs_reg <= ofs_reg + bdc_pkg::WORD_BYTES;
      end
      if (pop) begin
        lb_reg.addr <= wrap_add(local_reg, ofs_reg); // RL9
        lb_reg.data <= fifo_od;
        lb_reg.tc <= cs_reg[bdc_pkg::TC_LSB +: 4]; // RL22
        lb_reg.size <= bdc_pkg::bdc_size_e'(
                         cs_reg[bdc_pkg::DEST_PORT_WIDTH_LSB +: 2]); // RL11
        lb_reg.burst <= burst_ok; // RL16
        lb_reg.swap <= GLOBAL_BYTE_ORDER
                       ^ cs_reg[bdc_pkg::ENDIAN_INVERT_BIT]; // RL12
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      off_reg <= bdc_pkg::OFF_0;
    end else if (lb_done && ((wrap_add(lb_reg.addr, bdc_pkg::WORD_BYTES)
                 & (cs_reg[bdc_pkg::MAX_BURST_SIZE_BIT] ? bdc_pkg::BND_NARROW
                    : bdc_pkg::BND_WIDE)) == bdc_pkg::ZERO_WORD)) begin
      off_reg <= off_cycles(cs_reg[bdc_pkg::QOFF_LSB +: 3]); // RL15
    end else if (off_reg != bdc_pkg::OFF_0) begin
      off_reg <= off_reg - 11'h001; // RL14
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_ACK = ack_reg;
  assign IN_READY = in_rdy_reg;
  assign PCI_REQ = pci_req_reg;
  assign PCI_ADDR = pci_reg;
  assign LB_VALID = lb_valid_reg;
  assign LB_BEAT = lb_reg;
  assign PKT_REQ = pkt_req_reg;
  assign PKT_ADDR = pkt_addr_reg;
  assign PKT_FROM_LOCAL = pkt_loc_reg;
  assign ACTIVE = active_reg;
  assign DONE = done_reg;
  assign STOPPED = stopped_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_PCI_ALIGN: assert property (pci_reg[1:0] == 2'b00) // RL1
    else $error("pci address not word aligned");
  AST_PCI_WRAP: assert property (push && !idle |=> // RL2
    pci_reg[31:24] == $past(pci_reg[31:24]))
    else $error("pci address left its 24-bit window");
  AST_CNT_DEC: assert property (push && !idle && !pkt_take |=> // RL3
    cnt_reg == $past(cnt_reg) - bdc_pkg::WORD_BYTES)
    else $error("count did not drop by four");
  AST_MIN_START: assert property (idle && START && !CHAIN_MODE // RL5
    && cnt_reg < bdc_pkg::MIN_BYTES |=> !ACTIVE)
    else $error("channel started below minimum count");
  AST_PKT_CNT: assert property (pkt_take |=> // RL7
    cnt_reg[31:20] == 12'h000)
    else $error("packet count beyond one megabyte");
  AST_LOCAL_HOLD: assert property (!idle && !pkt_take |=> // RL9
    $stable(local_reg))
    else $error("local address changed during transfer");
  AST_DIR_MIRROR: assert property (REG_RD && REG_ADDR == // RL10
    bdc_pkg::OFF_CTRL |=> REG_RDATA[bdc_pkg::DIR_BIT] == $past(SHARED_DIR))
    else $error("direction bit not mirrored");
  AST_OFF_HOLD: assert property (off_reg != bdc_pkg::OFF_0 |-> // RL14
    !pop)
    else $error("local request during off count");
  AST_TC: assert property (pop |=> // RL22
    LB_BEAT.tc == $past(cs_reg[bdc_pkg::TC_LSB +: 4]) && LB_VALID)
    else $error("transaction code not driven");
  AST_STOP: assert property (stop |-> !push && !pop) // RL19
    else $error("data moved while stopped");
  AST_DONE: assert property (state_reg == bdc_pkg::ST_DRAIN // RL24
    && drained && !(chain_reg && !last_reg) |=> DONE && !ACTIVE)
    else $error("done not reported at count expiry");

  COV_DIRECT: cover property (state_reg == bdc_pkg::ST_DRAIN
    && drained && !chain_reg);
  COV_CHAIN: cover property (pkt_take ##[1:200] pkt_take);
  COV_STOP: cover property (STOPPED ##1 !STOPPED && ACTIVE);
  COV_OFF: cover property (off_reg == bdc_pkg::OFF_64);

endmodule : bdc_dma_channel

// ### bdc_lb_partner.sv
`timescale 1ns/1ns

module bdc_lb_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic lb_valid,
  input wire bdc_pkg::bdc_lb_s lb_beat,
  output logic lb_ack,
  input wire logic pkt_req,
  input wire bdc_pkg::bdc_pkt_s pkt_img,
  output logic pkt_valid,
  output bdc_pkg::bdc_pkt_s pkt
);
  bdc_pkg::bdc_lb_s beats [16];
  int n_beats;
  logic phase_reg;

  initial begin
    lb_ack = 1'b0;
    pkt_valid = 1'b0;
    pkt = '0;
    n_beats = 0;
    phase_reg = 1'b0;
  end

  // ---------------------------------------------------------------
  // acceptor and packet memory
  // ---------------------------------------------------------------
  // slow mode acks every other cycle; idle packet lines toggle
  always @(negedge clk) begin
    phase_reg <= ~phase_reg;
    lb_ack <= lb_valid && (!slow || phase_reg);
    pkt_valid <= pkt_req;
    pkt <= pkt_req ? pkt_img : ~pkt;
  end

  always @(posedge clk) begin
    if (rst_n && lb_valid && lb_ack && n_beats < 16) begin
      beats[n_beats] <= lb_beat;
      n_beats <= n_beats + 1;
    end
  end
endmodule : bdc_lb_partner

// ### bdc_dma_channel_test.sv
`timescale 1ns/1ns

module bdc_dma_channel_test;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} bdc_row_s;
  logic CLK, RST_N, REG_WR, REG_RD, START, CHAIN_MODE, SHARED_DIR, slow, gbo;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, IN_DATA, PCI_ADDR, PKT_ADDR;
  logic REG_ACK, IN_VALID, IN_READY, PCI_REQ, LB_VALID, LB_ACK, PKT_REQ;
  logic PKT_FROM_LOCAL, PKT_VALID, ACTIVE, DONE, STOPPED;
  bdc_pkg::bdc_lb_s LB_BEAT;
  bdc_pkg::bdc_pkt_s PKT, pkt_img;
  bdc_row_s rows [6];
  int failures, num_checks, k;

  bdc_dma_channel #(.DEPTH(4)) i_bdc_dma_channel (.CLK(CLK), .RST_N(RST_N),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .START(START), .CHAIN_MODE(CHAIN_MODE), .SHARED_DIR(SHARED_DIR),
    .GLOBAL_BYTE_ORDER(gbo), .BURST_MASTER_MODE(1'b0),
    .CACHE_LINE_SETTING(2'h0), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_READY(IN_READY), .PCI_REQ(PCI_REQ), .PCI_ADDR(PCI_ADDR),
    .LB_VALID(LB_VALID), .LB_ACK(LB_ACK), .LB_BEAT(LB_BEAT),
    .PKT_REQ(PKT_REQ), .PKT_ADDR(PKT_ADDR), .PKT_FROM_LOCAL(PKT_FROM_LOCAL),
    .PKT_VALID(PKT_VALID), .PKT(PKT), .ACTIVE(ACTIVE), .DONE(DONE),
    .STOPPED(STOPPED));

  bdc_lb_partner i_bdc_lb_partner (.clk(CLK), .rst_n(RST_N), .slow(slow),
    .lb_valid(LB_VALID), .lb_beat(LB_BEAT), .lb_ack(LB_ACK),
    .pkt_req(PKT_REQ), .pkt_img(pkt_img), .pkt_valid(PKT_VALID), .pkt(PKT));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, string nm);
    @(negedge CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    chk("ack", {31'h0, REG_ACK}, 32'h1);
    chk(nm, REG_RDATA, e);
  endtask : rd

  task automatic go;
    @(negedge CLK);
    START = 1'b1;
    @(negedge CLK);
    START = 1'b0;
  endtask : go

  task automatic feed(input int n);
    int i;
    logic rdy;
    i = 0;
    for (int t = 0; t < 300 && i < n; t++) begin
      @(negedge CLK);
      IN_VALID = 1'b1;
      IN_DATA = 32'hC0DE_0000 + i;
      rdy = IN_READY;
      @(posedge CLK);
      if (rdy === 1'b1) i++;
    end
    @(negedge CLK);
    IN_VALID = 1'b0;
    for (int t = 0; t < 300 && DONE !== 1'b1; t++) @(negedge CLK);
  endtask : feed

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  initial begin
    #500000;
    failures++;
    conclude;
  end

  initial begin
    rows = '{'{12'h404, 32'hFFFF_FFFF, 32'hFFFF_FFFC},
      '{12'h408, 32'hFFFF_FFFF, 32'h00FF_FFFC},
      '{12'h40C, 32'hFFFF_FFFF, 32'hFFFF_FFFC},
      '{12'h410, 32'hFFFF_FF3F, 32'hF7F7_C300},
      '{12'h414, 32'hFFFF_FFFF, 32'hFFFF_FFF0},
      '{12'h400, 32'hFFFF_FFFF, 32'h0000_0000}};
    {RST_N, REG_WR, REG_RD, START, CHAIN_MODE, SHARED_DIR, IN_VALID, gbo} = '0;
    {REG_ADDR, REG_WDATA, IN_DATA, failures, num_checks} = '0;
    slow = 1'b0;
    pkt_img = '0;
    repeat (5) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    for (k = 0; k < 6; k++) begin
      rd(rows[k].a, 32'h0, "reset value");
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a, rows[k].e, "field");
    end
    SHARED_DIR = 1'b1;
    wr(12'h410, 32'h0);
    rd(12'h410, 32'h0800_0000, "dir mirror");
    SHARED_DIR = 1'b0;
    wr(12'h408, 32'h0000_000C);
    go;
    repeat (3) @(negedge CLK);
    chk("short start", {31'h0, ACTIVE}, 32'h0);
    // direct transfer across the 24-bit wrap
    wr(12'h404, 32'h00FF_FFF8);
    wr(12'h408, 32'h0000_0010);
    wr(12'h40C, 32'h0000_1000);
    wr(12'h410, 32'hA000_0000);
    go;
    feed(4);
    chk("done idle", {30'h0, ACTIVE, DONE}, 32'h1);
    chk("pci addr", PCI_ADDR, 32'h0000_0008);
    rd(12'h408, 32'h0, "count");
    rd(12'h40C, 32'h0000_1000, "local addr");
    for (k = 0; k < 4; k++) begin
      chk("addr", i_bdc_lb_partner.beats[k].addr, 32'h1000 + 4 * k);
      chk("data", i_bdc_lb_partner.beats[k].data, 32'hC0DE_0000 + k);
      chk("tc", {28'h0, i_bdc_lb_partner.beats[k].tc}, 32'hA);
      chk("size", {30'h0, i_bdc_lb_partner.beats[k].size}, 32'h0);
    end
    // linked list, one packet, slow acceptor
    slow = 1'b1;
    gbo = 1'b1;
    pkt_img = '{32'h100, 32'h3000, 32'h3000_0010, 32'h4001};
    wr(12'h414, 32'h0000_2000);
    wr(12'h410, 32'h0000_0100);
    CHAIN_MODE = 1'b1;
    go;
    chk("pkt addr", PKT_ADDR, 32'h0000_2000);
    chk("pkt loc", {31'h0, PKT_FROM_LOCAL}, 32'h1);
    feed(4);
    rd(12'h414, 32'h0000_4000, "pointer");
    rd(12'h410, 32'h3000_0100, "ctrl load");
    rd(12'h404, 32'h0000_0110, "pci load");
    rd(12'h40C, 32'h0000_3000, "local load");
    chk("tc", {28'h0, i_bdc_lb_partner.beats[7].tc}, 32'h3);
    chk("beats", i_bdc_lb_partner.n_beats, 32'h8);
    // stopped before data, then resumed
    CHAIN_MODE = 1'b0;
    wr(12'h408, 32'h0000_0010);
    wr(12'h410, 32'h0100_0080);
    go;
    chk("stopped", {30'h0, STOPPED, PCI_REQ}, 32'h2);
    rd(12'h410, 32'h0100_00C0, "stop stat");
    wr(12'h410, 32'h0100_0000);
    chk("resume", {30'h0, PCI_REQ, IN_READY}, 32'h3);
    feed(4);
    chk("swap", {30'h0, i_bdc_lb_partner.beats[7].swap,
      i_bdc_lb_partner.beats[8].swap}, 32'h2);
    chk("stop done", {31'h0, DONE}, 32'h1);
    conclude;
  end
endmodule : bdc_dma_channel_test
